// ---- adcp_pkg.sv ----
// Operation
// RULE1 - power-down input high selects power-down, low selects normal operation
// RULE2 - output enable low drives the data outputs, high disables them
// RULE3 - ten-bit parallel three-state result, top bit is the MSB, bit zero LSB
// RULE4 - each sample appears at the outputs five and a half clocks later
// RULE5 - samples advance one pipeline stage on every conversion clock edge
// RULE6 - a new sample is taken on each falling conversion clock edge
// RULE7 - ten redundant 1.5-bit stages merged by digital error correction
// RULE8 - output word changes on rising edges; receiver captures on rising edges
// RULE9 - outputs float while output enable and power-down are both high
// RULE10 - enable low during power-down holds the last word made before it
// RULE11 - straight offset binary: zeros, midscale MSB only, all ones full scale
package adcp_pkg;
    localparam int RES_BITS = 10;
    localparam int NUM_STAGES = 10;
    localparam int STAGE_CODE_W = 2;
    localparam int CODES_W = NUM_STAGES * STAGE_CODE_W;
    // latency in half cycles of the conversion clock: 5.5 cycles
    localparam int LATENCY_HALF_CYCLES = 11;
    // the output latch supplies the last half step
    localparam int PIPE_SLOTS = LATENCY_HALF_CYCLES - 1;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] CODE_LOW = 2'h0;
    localparam logic [1:0] CODE_MID = 2'h1;
    localparam logic [RES_BITS-1:0] WORD_NEG_FULL = 10'h000;
    localparam logic [RES_BITS-1:0] WORD_BIPOLAR_ZERO = 10'h200;
    localparam logic [RES_BITS-1:0] WORD_POS_FULL = 10'h3FF;
    localparam logic [RES_BITS-1:0] RESET_WORD = 10'h000;
    localparam int ACC_W = RES_BITS + 3;
endpackage : adcp_pkg

// ---- adcp_half_pipe.sv ----
`timescale 1ns/1ns
`default_nettype none
module adcp_half_pipe #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 10
) (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic advance, // one half step of the pipeline
    input wire logic load_new, // take din into the first slot
    input wire logic [WIDTH-1:0] din, // freshly sampled stage codes
    output logic [WIDTH-1:0] dout // last slot, registered
);
    logic [WIDTH-1:0] slot_q [DEPTH];
    logic [WIDTH-1:0] head_d;

    // between falling edges the head keeps its sample so every slot shifts each edge
    assign head_d = load_new ? din : slot_q[0];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                slot_q[i] <= '0;
            end
        end else if (advance) begin
            slot_q[0] <= head_d;
            for (int i = 1; i < DEPTH; i++) begin
                slot_q[i] <= slot_q[i-1];
            end
        end
    end

    assign dout = slot_q[DEPTH-1];
endmodule : adcp_half_pipe
`default_nettype wire

// ---- adcp_output_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module adcp_output_port #(
    parameter int RES_BITS = adcp_pkg::RES_BITS,
    parameter int NUM_STAGES = adcp_pkg::NUM_STAGES
) (
    input wire logic clk_sys, // 250 MHz system clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic conv_clk_in, // conversion clock pin, sampled
    input wire logic power_down_in, // high selects power-down
    input wire logic out_enable_n_in, // low enables the data outputs
    input wire logic [adcp_pkg::CODES_W-1:0] stage_codes_in, // 1.5-bit codes, stage 0 low
    output logic [RES_BITS-1:0] conversion_result_bits, // result word, bit 9 MSB
    output logic conversion_result_oe_n, // low while the bus is driven
    output logic power_down_status // synchronised power-down level
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic clk_m_q, clk_s_q, clk_prev_q;
    logic pd_m_q, pd_s_q;
    logic oe_n_m_q, oe_n_s_q;
    logic [adcp_pkg::CODES_W-1:0] codes_m_q, codes_s_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_m_q <= 1'b0;
            clk_s_q <= 1'b0;
            clk_prev_q <= 1'b0;
            pd_m_q <= 1'b0;
            pd_s_q <= 1'b0;
            oe_n_m_q <= 1'b1;
            oe_n_s_q <= 1'b1;
            codes_m_q <= '0;
            codes_s_q <= '0;
        end else begin
            clk_m_q <= conv_clk_in;
            clk_s_q <= clk_m_q;
            clk_prev_q <= clk_s_q;
            pd_m_q <= power_down_in;
            pd_s_q <= pd_m_q;
            oe_n_m_q <= out_enable_n_in;
            oe_n_s_q <= oe_n_m_q;
            codes_m_q <= stage_codes_in;
            codes_s_q <= codes_m_q;
        end
    end

    // ------------------------------------------------------------
    // edge events and pipeline
    // ------------------------------------------------------------
    wire conv_rise = clk_s_q & ~clk_prev_q;
    wire conv_fall = ~clk_s_q & clk_prev_q;
    // power-down freezes the sample, pipeline step and output latch, so no sample or edge is lost half-way
    wire running = ~pd_s_q; // RULE1
    wire half_step = (conv_rise | conv_fall) & running; // RULE5
    wire take_sample = conv_fall & running; // RULE6
    wire latch_out = conv_rise & running; // RULE8

    logic [adcp_pkg::CODES_W-1:0] pipe_tail;

    adcp_half_pipe #(
        .WIDTH(adcp_pkg::CODES_W),
        .DEPTH(adcp_pkg::PIPE_SLOTS) // RULE4
    ) u_pipe (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .advance(half_step),
        .load_new(take_sample),
        .din(codes_s_q),
        .dout(pipe_tail)
    );

    // ------------------------------------------------------------
    // digital error correction
    // ------------------------------------------------------------
    // each stage adds -1, 0 or +1 (code 0, code 1, code 2 or 3) at its weight around midscale; the overlap of
    // adjacent stages absorbs comparator offsets, so no code goes missing
    function automatic logic [adcp_pkg::RES_BITS-1:0] correct_word(
        input logic [adcp_pkg::CODES_W-1:0] codes
    );
        logic signed [adcp_pkg::ACC_W-1:0] acc;
        logic signed [adcp_pkg::ACC_W-1:0] weight;
        logic [1:0] code;
        acc = adcp_pkg::ACC_W'(adcp_pkg::WORD_BIPOLAR_ZERO); // RULE11
        for (int i = 0; i < adcp_pkg::NUM_STAGES; i++) begin
            code = codes[i*adcp_pkg::STAGE_CODE_W +: adcp_pkg::STAGE_CODE_W];
            weight = adcp_pkg::ACC_W'(1) <<< (adcp_pkg::NUM_STAGES - 1 - i);
            // stage 0 carries the heaviest weight; code 3 is taken as high
            if (code == adcp_pkg::CODE_LOW) begin
                acc = acc - weight; // RULE7
            end else if (code != adcp_pkg::CODE_MID) begin
                acc = acc + weight; // RULE7
            end
        end
        // clamp the redundant overrange to the end codes
        if (acc < 0) begin
            correct_word = adcp_pkg::WORD_NEG_FULL;
        end else if (acc > adcp_pkg::ACC_W'(adcp_pkg::WORD_POS_FULL)) begin
            correct_word = adcp_pkg::WORD_POS_FULL;
        end else begin
            correct_word = acc[adcp_pkg::RES_BITS-1:0];
        end
    endfunction : correct_word

    wire [RES_BITS-1:0] corrected_word = correct_word(pipe_tail);

    // ------------------------------------------------------------
    // output latch and bus enable
    // ------------------------------------------------------------
    logic [RES_BITS-1:0] result_q, result_d;
    logic oe_n_q;
    logic pd_q;

    // output latch holds its word through power-down
    assign result_d = latch_out ? corrected_word : result_q; // RULE4 RULE10

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_q <= adcp_pkg::RESET_WORD;
            oe_n_q <= 1'b1;
            pd_q <= 1'b0;
        end else begin
            result_q <= result_d; // RULE3
            oe_n_q <= oe_n_s_q; // RULE2 RULE9
            pd_q <= pd_s_q; // RULE1
        end
    end

    assign conversion_result_bits = result_q;
    assign conversion_result_oe_n = oe_n_q;
    assign power_down_status = pd_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_pd_seen;
        pd_s_q ##1 pd_s_q;
    endsequence

    // synchronised pin seen low then high, or high then low
    sequence s_pin_rise;
        !clk_s_q ##1 clk_s_q;
    endsequence

    sequence s_pin_fall;
        clk_s_q ##1 !clk_s_q;
    endsequence

    // ------------------------------------------------------------
    // mode and bus enable checks
    // ------------------------------------------------------------
    a_pd_status_follows: assert property (pd_s_q |=> power_down_status) // RULE1
        else $error("power-down status did not follow the input");

    a_pd_status_low: assert property (!pd_s_q |=> !power_down_status) // RULE1
        else $error("power-down status stayed high in normal operation");

    a_oe_disable: assert property (oe_n_s_q |=> conversion_result_oe_n) // RULE2
        else $error("outputs stayed enabled with enable high");

    a_oe_enable: assert property (!oe_n_s_q |=> !conversion_result_oe_n) // RULE2
        else $error("outputs not driven with enable low");

    a_hiz_in_pd: assert property ((oe_n_s_q && pd_s_q) |=> conversion_result_oe_n) // RULE9
        else $error("outputs driven while disabled in power-down");

    // ------------------------------------------------------------
    // edge and pipeline checks
    // ------------------------------------------------------------
    a_rise_latches: assert property ( // RULE8
        s_pin_rise ##0 !pd_s_q |-> latch_out && half_step)
        else $error("rising conversion edge did not step and latch");

    a_fall_samples: assert property ( // RULE6
        s_pin_fall ##0 !pd_s_q |-> take_sample && half_step)
        else $error("falling conversion edge did not take a sample");

    a_no_sample_rise: assert property (take_sample |-> !conv_rise && half_step) // RULE6
        else $error("sample taken away from a falling edge");

    a_pd_no_step: assert property (pd_s_q |-> !half_step) // RULE5
        else $error("pipeline advanced during power-down");

    // a frozen tail keeps the words in flight intact across power-down
    a_tail_frozen: assert property (pd_s_q |=> $stable(pipe_tail)) // RULE5
        else $error("pipeline tail moved during power-down");

    // ------------------------------------------------------------
    // output word checks
    // ------------------------------------------------------------
    a_pd_hold_word: assert property (s_pd_seen |=> $stable(conversion_result_bits)) // RULE10
        else $error("result word changed during power-down");

    a_word_on_rise: assert property ( // RULE8
        !$stable(conversion_result_bits) |-> $past(conv_rise) && !$past(pd_s_q))
        else $error("result word changed away from a rising edge");

    a_latch_value: assert property ( // RULE4
        latch_out |=> conversion_result_bits == $past(corrected_word))
        else $error("output latch did not take the corrected word");

    a_midscale_code: assert property ( // RULE11
        (pipe_tail == {NUM_STAGES{adcp_pkg::CODE_MID}})
        |-> corrected_word == adcp_pkg::WORD_BIPOLAR_ZERO)
        else $error("all-midscale codes did not give bipolar zero");

    a_msb_weight: assert property ( // RULE3
        (pipe_tail[adcp_pkg::STAGE_CODE_W-1:0] == adcp_pkg::CODE_LOW)
        |-> !corrected_word[RES_BITS-1])
        else $error("low first-stage code set the most significant bit");

    a_neg_full: assert property ( // RULE11
        (pipe_tail == '0) |-> corrected_word == adcp_pkg::WORD_NEG_FULL)
        else $error("all-low codes did not give negative full scale");

    a_pos_full: assert property ( // RULE11
        (pipe_tail == '1) |-> corrected_word == adcp_pkg::WORD_POS_FULL)
        else $error("all-high codes did not give positive full scale");
endmodule : adcp_output_port
`default_nettype wire

// ---- adcp_capture_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------
// receiving logic on the result bus
// ----------------------------------
module adcp_capture_model (
    input wire logic conv_clk, // conversion clock, same one the converter sees
    input wire logic [adcp_pkg::RES_BITS-1:0] bus_in, // three-state result bus
    output logic [adcp_pkg::RES_BITS-1:0] captured // word taken at the rising edge
);
    // the word is only promised settled at the rising edge, so it is taken there
    always @(posedge conv_clk) begin
        captured <= bus_in;
    end
endmodule : adcp_capture_model
`default_nettype wire

// ---- adcp_output_port_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module adcp_output_port_bench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic conv_clk_in = 1'b0;
    logic power_down_in = 1'b0;
    logic out_enable_n_in = 1'b0;
    logic [adcp_pkg::CODES_W-1:0] stage_codes_in = 20'h55555;
    logic [adcp_pkg::RES_BITS-1:0] conversion_result_bits;
    logic conversion_result_oe_n;
    logic power_down_status;
    logic [adcp_pkg::RES_BITS-1:0] captured;
    wire [adcp_pkg::RES_BITS-1:0] result_bus;
    logic [adcp_pkg::RES_BITS-1:0] exp_q[$];
    int fails = 0;
    int checked = 0;
    int e = 0;
    // ----------------------------------
    // design, bus and receiver
    // ----------------------------------
    assign result_bus = conversion_result_oe_n ? {10{1'bz}} : conversion_result_bits;
    adcp_output_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_clk_in(conv_clk_in),
        .power_down_in(power_down_in), .out_enable_n_in(out_enable_n_in),
        .stage_codes_in(stage_codes_in), .conversion_result_bits(conversion_result_bits),
        .conversion_result_oe_n(conversion_result_oe_n), .power_down_status(power_down_status));
    adcp_capture_model rx (.conv_clk(conv_clk_in), .bus_in(result_bus), .captured(captured));
    always #2 clk_sys = ~clk_sys;
    // ----------------------------------
    // checking helpers
    // ----------------------------------
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    // offset binary sum of redundant stages, clamped to the code range
    function automatic logic [9:0] model(input logic [19:0] c);
        int s;
        s = 512;
        for (int i = 0; i < 10; i++) begin
            if (c[2*i+:2] == 2'h0) s -= (1 << (9 - i));
            else if (c[2*i+:2] != 2'h1) s += (1 << (9 - i));
        end
        if (s < 0) s = 0;
        if (s > 1023) s = 1023;
        return 10'(s);
    endfunction : model
    task automatic test_done;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // one conversion clock period of nine system clocks, high for four and low for five
    task automatic conv_cycle(input logic [19:0] codes, input bit frz_rise, input bit frz_fall,
                              input logic pd_after, input logic oe_after);
        logic oe_was;
        oe_was = out_enable_n_in;
        @(negedge clk_sys);
        conv_clk_in = 1'b1;
        stage_codes_in = codes;
        @(negedge clk_sys);
        if (e >= 7 && !oe_was) check("captured", captured, exp_q[e-7]);
        if (oe_was) check("bus float", captured, {10{1'bz}});
        if (!frz_rise) e++;
        power_down_in = pd_after;
        out_enable_n_in = oe_after;
        repeat (3) @(negedge clk_sys);
        conv_clk_in = 1'b0;
        if (!frz_fall) exp_q.push_back(model(codes));
        repeat (4) @(negedge clk_sys);
        check("oe_n", {9'h000, conversion_result_oe_n}, {9'h000, out_enable_n_in});
        check("pd_status", {9'h000, power_down_status}, {9'h000, power_down_in});
    endtask : conv_cycle
    // ----------------------------------
    // main sequence and watchdog
    // ----------------------------------
    initial begin
        logic [19:0] codes;
        void'($urandom(81));
        repeat (4) @(negedge clk_sys);
        check("reset word", conversion_result_bits, adcp_pkg::RESET_WORD);
        check("reset oe_n", {9'h000, conversion_result_oe_n}, 10'h001);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int n = 0; n < 70; n++) begin
            codes = 20'($urandom());
            if (n == 0) codes = 20'h55555;
            if (n == 1) codes = 20'h00000;
            if (n == 2) codes = 20'hAAAAA;
            if (n == 3) codes = 20'hFFFFF;
            // power-down spans cycles 30 to 35, output disabled inside it for two cycles
            // and once more at 50 and 51 in normal operation
            conv_cycle(codes, n >= 31 && n <= 36, n >= 30 && n <= 35, n >= 30 && n <= 35,
                       (n >= 32 && n <= 33) || (n >= 50 && n <= 51));
        end
        test_done();
    end
    initial begin
        #20000;
        fails++;
        test_done();
    end
endmodule : adcp_output_port_bench
`default_nettype wire
